// ---- tde_params.svh ----
`ifndef TDE_PARAMS_SVH
`define TDE_PARAMS_SVH
// ==========================================================
// register map (low 16 bits of the bus address)
`define TDE_PRAM_BASE   16'h4000
`define TDE_PRAM_MASK   16'hF000
`define TDE_LINK_BASE   16'h4800
`define TDE_DMAP_BASE   16'h1000
`define TDE_DMAP_MASK   16'hFF00
`define TDE_QMAP_BASE   16'h1100
`define TDE_QMAP_MASK   16'hFFE0
`define TDE_STAT_OFF    16'h1200
`define TDE_CTRL_OFF    16'h1204
`define TDE_CTRL_RST    1'b1
// ==========================================================
// parameter set fields
`define TDE_MODE_BIT    2
`define TDE_CODE_POS    12
`define TDE_NULL_LINK   16'hFFFF
// ==========================================================
// sizes and bus answers
`define TDE_DST_DEPTH   3'h4
`define TDE_DF_DEPTH    5'h10
`define TDE_AXI_OKAY    2'b00
`define TDE_AXI_SLVERR  2'b10
`endif

// ---- tde_pkg.sv ----
package tde_pkg;
  // one transfer request as held in program, active and dst sets
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] nbyte;
    logic [15:0] narr;
    logic [15:0] sbidx;
    logic [15:0] dbidx;
    logic [5:0]  tcc;
  } tde_req_s;

  // register regions seen by the bus slave
  typedef enum logic [2:0] {
    TDE_R_NONE = 3'b000,
    TDE_R_PRAM = 3'b001,
    TDE_R_DMAP = 3'b010,
    TDE_R_QMAP = 3'b011,
    TDE_R_STAT = 3'b100,
    TDE_R_CTRL = 3'b101
  } tde_reg_e;
endpackage

// ---- tde_top.sv ----
// Operation
// - each incoming request is first held in the program set
// - when idle the first request moves at once to active and dst sets
// - a second request waits in program set until active set is exhausted
// - reads are issued only while the data fifo has room for them
// - writes start once data is present in the data fifo
// - reads may run up to four requests ahead of writes
// - a completion code is sent when a transfer finishes
// - transfers are arrays of bytes, frames of arrays, blocks of frames
// - arrays step by array index, frames by frame index
// - one option bit selects array-sync or frame-sync mode
// - array-sync: one array per trigger, frames times arrays triggers
// - next array start is previous start plus signed array index
// - array-sync: frame index added to last array start of frame
// - frame-sync: one whole frame per trigger, frame count triggers
// - frame-sync: frame index added to first array start of frame
// - parameter ram holds 128 sets of eight 32-bit words
// - any of the 128 sets can serve a dma channel, all sets usable for link
// - after reset every dma channel maps to set 0
// - set n lives at base plus 32 times n, link field bits 11:5 pick any set
// - each of 8 quick trigger channels maps to any set 0 to 127
// - array-sync: array count decrements, reloads, frame count drops
// - frame-sync: array count travels in request, engine counts it
// - link of all ones means no set is copied when exhausted
`timescale 1ns/10ps
`include "tde_params.svh"
module tde_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        TRIG_VALID,
  input  wire logic        TRIG_QUICK,
  input  wire logic [5:0]  TRIG_CHAN,
  output logic             TRIG_READY,
  output logic             RD_VALID,
  input  wire logic        RD_READY,
  output logic [31:0]      RD_ADDR,
  input  wire logic        RD_RVALID,
  input  wire logic [7:0]  RD_RDATA,
  output logic             WR_VALID,
  input  wire logic        WR_READY,
  output logic [31:0]      WR_ADDR,
  output logic [7:0]       WR_DATA,
  output logic             CMPL_VALID,
  output logic [5:0]       CMPL_CODE
);
  import tde_pkg::*;

  // ==========================================================
  // storage
  logic [31:0] pram [1024];
  logic [6:0]  dmap_r [64];
  logic [6:0]  qmap_r [8];
  logic        en_r;
  logic        awrdy_r, bvalid_r, arrdy_r, rvalid_r, trdy_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r, wmrg;
  tde_reg_e    wreg, rreg;
  tde_req_s    prog_r, act_r, hd, req_nxt;
  tde_req_s    dq_r [4];
  logic        prog_v, act_v, mv, trig_take, tnull, texh;
  logic [6:0]  tset, lset;
  logic [31:0] pw [8];
  logic [31:0] lw [8];
  logic [31:0] nw [8];
  logic [1:0]  wp, rp;
  logic [2:0]  dq_cnt;
  logic [7:0]  df [16];
  logic [3:0]  dwp, drp;
  logic [4:0]  dcnt, rd_out;
  logic [15:0] rd_b, wr_b;
  logic        rd_v_r, rd_go, wr_v_r, wr_go, wr_acc, wr_last_r;
  logic [31:0] rd_a_r, wr_a_r;
  logic [7:0]  wr_d_r;
  logic        cv_r;
  logic [5:0]  cc_r;

  assign AWREADY    = awrdy_r;
  assign WREADY     = awrdy_r;
  assign BVALID     = bvalid_r;
  assign BRESP      = bresp_r;
  assign ARREADY    = arrdy_r;
  assign RVALID     = rvalid_r;
  assign RRESP      = rresp_r;
  assign RDATA      = rdata_r;
  assign TRIG_READY = trdy_r;
  assign RD_VALID   = rd_v_r;
  assign RD_ADDR    = rd_a_r;
  assign WR_VALID   = wr_v_r;
  assign WR_ADDR    = wr_a_r;
  assign WR_DATA    = wr_d_r;
  assign CMPL_VALID = cv_r;
  assign CMPL_CODE  = cc_r;

  // ==========================================================
  // helpers
  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic tde_reg_e reg_of(input logic [31:0] a);
    if ((a[15:0] & `TDE_PRAM_MASK) == `TDE_PRAM_BASE) return TDE_R_PRAM;
    if ((a[15:0] & `TDE_DMAP_MASK) == `TDE_DMAP_BASE) return TDE_R_DMAP;
    if ((a[15:0] & `TDE_QMAP_MASK) == `TDE_QMAP_BASE) return TDE_R_QMAP;
    if ({a[15:2], 2'b00} == `TDE_STAT_OFF) return TDE_R_STAT;
    if ({a[15:2], 2'b00} == `TDE_CTRL_OFF) return TDE_R_CTRL;
    return TDE_R_NONE;
  endfunction

  function automatic logic [31:0] reg_rd(input logic [31:0] a);
    unique case (reg_of(a))
      TDE_R_PRAM: return pram[a[11:2]];
      TDE_R_DMAP: return {25'h000_0000, dmap_r[a[7:2]]};
      TDE_R_QMAP: return {25'h000_0000, qmap_r[a[4:2]]};
      TDE_R_STAT: return {19'h0_0000, prog_v, act_v, dq_cnt, 3'h0, dcnt};
      TDE_R_CTRL: return {31'h0000_0000, en_r};
      default:    return 32'h0000_0000;
    endcase
  endfunction

  // byte-lane merge of a write into the current value
  always_comb begin
    wreg = reg_of(AWADDR);
    rreg = reg_of(ARADDR);
    wmrg = reg_rd(AWADDR);
    for (int i = 0; i < 4; i++) begin
      if (WSTRB[i]) wmrg[8*i +: 8] = WDATA[8*i +: 8];
    end
  end

  // ==========================================================
  // axi4-lite slave: address and data taken together
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      awrdy_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= `TDE_AXI_OKAY;
    end else begin
      awrdy_r <= AWVALID && WVALID && !awrdy_r && !bvalid_r;
      if (awrdy_r) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wreg == TDE_R_NONE || wreg == TDE_R_STAT) ?
                    `TDE_AXI_SLVERR : `TDE_AXI_OKAY;
      end else if (BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel: one cycle ready, data the next
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      arrdy_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r  <= `TDE_AXI_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else begin
      arrdy_r <= ARVALID && !arrdy_r && !rvalid_r;
      if (arrdy_r) begin
        rvalid_r <= 1'b1;
        rdata_r  <= reg_rd(ARADDR);
        rresp_r  <= (rreg == TDE_R_NONE) ? `TDE_AXI_SLVERR : `TDE_AXI_OKAY;
      end else if (RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // channel maps and control; maps cover all 128 sets
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < 64; i++) dmap_r[i] <= 7'h00;
      for (int i = 0; i < 8; i++) qmap_r[i] <= 7'h00;
      en_r <= `TDE_CTRL_RST;
    end else if (awrdy_r) begin
      if (wreg == TDE_R_DMAP) dmap_r[AWADDR[7:2]] <= wmrg[6:0];
      if (wreg == TDE_R_QMAP) qmap_r[AWADDR[4:2]] <= wmrg[6:0];
      if (wreg == TDE_R_CTRL) en_r <= wmrg[0];
    end
  end

  // ==========================================================
  // trigger service: build request and update the set
  always_comb begin
    tset = TRIG_QUICK ? qmap_r[TRIG_CHAN[2:0]] : dmap_r[TRIG_CHAN];
    for (int i = 0; i < 8; i++) pw[i] = pram[{tset, 3'(i)}];
    lset = pw[5][11:5];
    for (int i = 0; i < 8; i++) lw[i] = pram[{lset, 3'(i)}];
    nw = pw;
    req_nxt.src   = pw[1];
    req_nxt.dst   = pw[3];
    req_nxt.nbyte = pw[2][15:0];
    req_nxt.narr  = pw[2][31:16];
    req_nxt.sbidx = pw[4][15:0];
    req_nxt.dbidx = pw[4][31:16];
    req_nxt.tcc   = pw[0][`TDE_CODE_POS +: 6];
    tnull = pw[2][15:0] == 16'h0000 || pw[2][31:16] == 16'h0000 ||
            pw[7][15:0] == 16'h0000;
    if (!pw[0][`TDE_MODE_BIT]) begin
      req_nxt.narr = 16'h0001;
      texh = pw[2][31:16] == 16'h0001 && pw[7][15:0] == 16'h0001;
      if (pw[2][31:16] != 16'h0001) begin
        nw[2][31:16] = pw[2][31:16] - 16'h0001;
        nw[1] = pw[1] + sx(pw[4][15:0]);
        nw[3] = pw[3] + sx(pw[4][31:16]);
      end else begin
        nw[2][31:16] = pw[5][31:16];
        nw[7][15:0]  = pw[7][15:0] - 16'h0001;
        nw[1] = pw[1] + sx(pw[6][15:0]);
        nw[3] = pw[3] + sx(pw[6][31:16]);
      end
    end else begin
      texh = pw[7][15:0] == 16'h0001;
      nw[7][15:0] = pw[7][15:0] - 16'h0001;
      nw[1] = pw[1] + sx(pw[6][15:0]);
      nw[3] = pw[3] + sx(pw[6][31:16]);
    end
    if (texh && pw[5][15:0] != `TDE_NULL_LINK) nw = lw;
  end

  assign trig_take = TRIG_VALID && trdy_r;

  // parameter ram write port; a bus write lands after a set update
  always_ff @(posedge REF_CLK) begin
    if (trig_take && !tnull) begin
      for (int i = 0; i < 8; i++) pram[{tset, 3'(i)}] <= nw[i];
    end
    if (awrdy_r && wreg == TDE_R_PRAM) pram[AWADDR[11:2]] <= wmrg;
  end

  // ==========================================================
  // program set and its hand-off
  assign mv = prog_v && !act_v && dq_cnt < `TDE_DST_DEPTH;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      prog_v <= 1'b0;
      trdy_r <= 1'b0;
      prog_r <= '0;
    end else begin
      if (trig_take && !tnull) begin
        prog_v <= 1'b1;
        prog_r <= req_nxt;
      end else if (mv) begin
        prog_v <= 1'b0;
      end
      trdy_r <= en_r && !trig_take && !(prog_v && !mv);
    end
  end

  // ==========================================================
  // read controller over the source active set
  assign rd_go = act_v && !rd_v_r &&
                 (6'(dcnt) + 6'(rd_out)) < 6'(`TDE_DF_DEPTH);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      act_v  <= 1'b0;
      act_r  <= '0;
      rd_b   <= 16'h0000;
      rd_v_r <= 1'b0;
      rd_a_r <= 32'h0000_0000;
    end else begin
      if (mv) begin
        act_v <= 1'b1;
        act_r <= prog_r;
      end
      if (rd_v_r && RD_READY) rd_v_r <= 1'b0;
      if (rd_go) begin
        rd_v_r <= 1'b1;
        rd_a_r <= act_r.src + {16'h0000, rd_b};
        if (rd_b == act_r.nbyte - 16'h0001) begin
          rd_b      <= 16'h0000;
          act_r.src <= act_r.src + sx(act_r.sbidx);
          act_r.narr <= act_r.narr - 16'h0001;
          if (act_r.narr == 16'h0001) act_v <= 1'b0;
        end else begin
          rd_b <= rd_b + 16'h0001;
        end
      end
    end
  end

  // outstanding reads and data fifo
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_out <= 5'h00;
      dcnt   <= 5'h00;
      dwp    <= 4'h0;
      drp    <= 4'h0;
    end else begin
      rd_out <= rd_out + 5'(rd_go) - 5'(RD_RVALID);
      dcnt   <= dcnt + 5'(RD_RVALID) - 5'(wr_go);
      if (RD_RVALID) begin
        df[dwp] <= RD_RDATA;
        dwp     <= dwp + 4'h1;
      end
      if (wr_go) drp <= drp + 4'h1;
    end
  end

  // ==========================================================
  // write controller over the destination fifo head
  assign hd     = dq_r[rp];
  assign wr_go  = dq_cnt != 3'h0 && !wr_v_r && dcnt != 5'h00;
  assign wr_acc = wr_v_r && WR_READY;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wp        <= 2'h0;
      rp        <= 2'h0;
      dq_cnt    <= 3'h0;
      wr_b      <= 16'h0000;
      wr_v_r    <= 1'b0;
      wr_last_r <= 1'b0;
      wr_a_r    <= 32'h0000_0000;
      wr_d_r    <= 8'h00;
      cv_r      <= 1'b0;
      cc_r      <= 6'h00;
      for (int i = 0; i < 4; i++) dq_r[i] <= '0;
    end else begin
      dq_cnt <= dq_cnt + 3'(mv) - 3'(wr_acc && wr_last_r);
      if (mv) begin
        dq_r[wp] <= prog_r;
        wp       <= wp + 2'h1;
      end
      if (wr_go) begin
        wr_v_r <= 1'b1;
        wr_a_r <= hd.dst + {16'h0000, wr_b};
        wr_d_r <= df[drp];
        wr_last_r <= wr_b == hd.nbyte - 16'h0001 && hd.narr == 16'h0001;
        if (wr_b == hd.nbyte - 16'h0001) begin
          wr_b <= 16'h0000;
          dq_r[rp].dst  <= hd.dst + sx(hd.dbidx);
          dq_r[rp].narr <= hd.narr - 16'h0001;
        end else begin
          wr_b <= wr_b + 16'h0001;
        end
      end else if (wr_acc) begin
        wr_v_r <= 1'b0;
      end
      cv_r <= wr_acc && wr_last_r;
      if (wr_acc && wr_last_r) begin
        cc_r <= hd.tcc;
        rp   <= rp + 2'h1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_trig_ready: assert property (TRIG_READY |-> !prog_v)
    else $error("trigger accepted while program set is full");
  a_prog_move: assert property (mv |=> act_v && dq_cnt != 3'h0)
    else $error("program set did not move to active set");
  a_fifo_space: assert property (
    (6'(dcnt) + 6'(rd_out)) <= 6'(`TDE_DF_DEPTH))
    else $error("reads exceed data fifo space");
  a_wr_data: assert property ($rose(WR_VALID) |-> $past(dcnt) != 5'h00)
    else $error("write issued with empty data fifo");
  a_dq_limit: assert property (dq_cnt <= `TDE_DST_DEPTH)
    else $error("destination fifo over four entries");
  a_cmpl_code: assert property (
    wr_acc && wr_last_r ##1 1'b1 |-> CMPL_VALID
    && CMPL_CODE == $past(hd.tcc))
    else $error("completion missing or wrong code");
  a_amode_one: assert property (
    trig_take && !tnull && !pw[0][`TDE_MODE_BIT]
    |=> prog_r.narr == 16'h0001)
    else $error("array-sync request holds more than one array");
  a_rd_hold: assert property (
    RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_ADDR))
    else $error("read request dropped before taken");
  a_map_reset: assert property (
    $past(RST) |-> dmap_r[0] == 7'h00 && dmap_r[63] == 7'h00)
    else $error("channel map not zero after reset");

  c_amode: cover property (trig_take && !pw[0][`TDE_MODE_BIT]);
  c_abmode: cover property (trig_take && pw[0][`TDE_MODE_BIT]);
  c_dq_full: cover property (dq_cnt == `TDE_DST_DEPTH);
  c_cmpl: cover property (CMPL_VALID);
endmodule

// ---- tde_mem_model.sv ----
`timescale 1ns/10ps
module tde_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rd_valid,
  output logic             rd_ready,
  input  wire logic [31:0] rd_addr,
  output logic             rd_rvalid,
  output logic [7:0]       rd_rdata,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [31:0] wr_addr,
  input  wire logic [7:0]  wr_data
);
  // ==========================================================
  // byte memory behind both ports
  logic [7:0] mem [0:4095];
  logic       slow_r;

  // address-dependent pattern so a misplaced byte shows
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end

  // slave answers every other cycle; idle data toggles, never holds
  always @(posedge clk) begin
    if (rst) begin
      rd_ready  <= 1'b0;
      rd_rvalid <= 1'b0;
      rd_rdata  <= 8'h00;
      wr_ready  <= 1'b0;
      slow_r    <= 1'b0;
    end else begin
      slow_r    <= ~slow_r;
      rd_ready  <= rd_valid & ~rd_ready & slow_r;
      rd_rvalid <= rd_valid & rd_ready;
      rd_rdata  <= (rd_valid & rd_ready) ? mem[rd_addr[11:0]] : ~rd_rdata;
      wr_ready  <= wr_valid & ~wr_ready & ~slow_r;
      if (wr_valid & wr_ready) begin
        mem[wr_addr[11:0]] <= wr_data;
      end
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // clock, reset and pins
  logic        clk = 1'b0, rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rv;
  logic [31:0] rd_addr, wr_addr;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rr;
  logic [5:0]  trig_chan = 6'h00, cmpl_code, last_code;
  logic [7:0]  rd_rdata, wr_data;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, trig_valid = 1'b0, trig_quick = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trig_ready;
  logic rd_valid, rd_ready, rd_rvalid, wr_valid, wr_ready, cmpl_valid;
  int   fail_count = 0, checks = 0, cmpl_n = 0;

  tde_top i_tde_top (.REF_CLK(clk), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .TRIG_VALID(trig_valid), .TRIG_QUICK(trig_quick),
    .TRIG_CHAN(trig_chan), .TRIG_READY(trig_ready),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_ADDR(rd_addr),
    .RD_RVALID(rd_rvalid), .RD_RDATA(rd_rdata), .WR_VALID(wr_valid),
    .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
    .CMPL_VALID(cmpl_valid), .CMPL_CODE(cmpl_code));

  tde_mem_model i_tde_mem_model (.clk(clk), .rst(rst), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_rvalid(rd_rvalid),
    .rd_rdata(rd_rdata), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data));

  // free-running system clock
  always #5 clk = ~clk;

  // count completion pulses and keep the last code
  always @(posedge clk) begin
    if (cmpl_valid === 1'b1) begin
      cmpl_n++;
      last_code = cmpl_code;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // one trigger, held until the engine takes it
  task automatic trig(input logic q, input logic [5:0] c);
    @(posedge clk);
    trig_quick <= q;
    trig_chan  <= c;
    trig_valid <= 1'b1;
    do @(posedge clk); while (trig_ready !== 1'b1);
    trig_valid <= 1'b0;
  endtask

  // write all eight words of parameter set n
  task automatic set(input int n, input logic [31:0] w [8]);
    for (int i = 0; i < 8; i++) begin
      wr(32'h0000_4000 + 32'(n * 32 + i * 4), w[i], 4'hF);
    end
  endtask

  // destination bytes must carry the source pattern
  task automatic arr(input logic [31:0] s, d, input int n);
    for (int k = 0; k < n; k++) begin
      check("dst byte", {24'h00_0000, i_tde_mem_model.mem[d[11:0] + 12'(k)]},
            {24'h00_0000, 8'(s + k) ^ 8'hA5});
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #200000;
    fail_count++;
    end_of_test;
  end

  // ==========================================================
  // tests
  initial begin
    logic [31:0] s3 [8] = '{32'h0001_5000, 32'h0000_0100, 32'h0002_0003,
      32'h0000_0800, 32'h0010_0008, 32'h0002_FFFF, 32'h0040_0000,
      32'h0000_0002};
    logic [31:0] s100 [8] = '{32'h0002_A004, 32'h0000_0200, 32'h0003_0002,
      32'h0000_0A00, 32'h0004_FFFC, 32'h0000_4040, 32'h0100_0080,
      32'h0000_0001};
    logic [31:0] srcs [4] = '{32'h100, 32'h108, 32'h128, 32'h130};
    logic [31:0] dsts [4] = '{32'h800, 32'h810, 32'h850, 32'h860};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values, refusals and enable gating
    rd(32'h0000_1014);
    check("channel map", rv, 32'h0000_0000);
    rd(32'h0000_1204);
    check("control", rv, 32'h0000_0001);
    rd(32'h0000_2000);
    check("unmapped resp", 32'(rr), 32'h0000_0002);
    wr(32'h0000_1200, 32'h0000_0001, 4'hF);
    check("status write resp", 32'(rr), 32'h0000_0002);
    wr(32'h0000_1204, 32'h0000_0000, 4'hF);
    repeat (3) @(posedge clk);
    check("trigger gated", 32'(trig_ready), 32'h0000_0000);
    wr(32'h0000_1204, 32'h0000_0001, 4'hF);
    $display("test reset_and_map done");
    // array-sync set, four back-to-back triggers
    set(3, s3);
    wr(32'h0000_4078, 32'h0000_0020, 4'h1);
    rd(32'h0000_4078);
    check("strobe merge", rv, 32'h0040_0020);
    wr(32'h0000_1010, 32'h0000_0003, 4'hF);
    for (int i = 0; i < 4; i++) begin
      trig(1'b0, 6'h04);
    end
    while (cmpl_n < 4) @(posedge clk);
    check("array code", 32'(last_code), 32'h0000_0015);
    for (int i = 0; i < 4; i++) begin
      arr(srcs[i], dsts[i], 3);
    end
    rd(32'h0000_407C);
    check("frames left", rv, 32'h0000_0000);
    $display("test array_sync done");
    // frame-sync on a quick channel, negative index, link copy
    wr(32'h0000_4044, 32'h0000_0321, 4'hF);
    wr(32'h0000_405C, 32'h0000_0000, 4'hF);
    set(100, s100);
    wr(32'h0000_111C, 32'h0000_0064, 4'hF);
    trig(1'b1, 6'h07);
    while (cmpl_n < 5) @(posedge clk);
    check("frame code", 32'(last_code), 32'h0000_002A);
    check("one per frame", 32'(cmpl_n), 32'h0000_0005);
    arr(32'h200, 32'hA00, 2);
    arr(32'h1FC, 32'hA04, 2);
    arr(32'h1F8, 32'hA08, 2);
    rd(32'h0000_4C84);
    check("linked src", rv, 32'h0000_0321);
    rd(32'h0000_1200);
    check("status idle", rv, 32'h0000_0000);
    $display("test frame_sync done");
    end_of_test;
  end
endmodule
